// file: src/vfe_forward_ctl.sv
// forwarding engine control: two engines merge lines of four
// receive ports onto two outputs, plus apb registers and irq.
// assumes receive-side pins are asynchronous and held stable
// for at least one link clock period once raised.
//
// Operation
// [R1] duplicate bit copies output 0 onto 1
// [R2] aligned mode waits for all member ports
// [R3] send-when-ready forwards each ready line alone
// [R4] send-when-ready ignored for concat and short
// [R5] output 1 aligned mode field, resets 0
// [R6] output 0 aligned mode field, resets 0
// [R7] software never enables both modes together
// [R8] output 1 rotating mode, no alignment attempt
// [R9] output 0 rotating mode serves ready sources
// [R10] alignment loss sets per-output lost flag
// [R11] loss flagged only after one aligned frame
// [R12] lost flags clear when state is read
// [R13] aligned-now high while delivering aligned video
// [R14] aligned-now zero when aligned mode off
// [R15] port forward-off bit blocks that port
// [R16] output select bit steers port to output
// [R17] rotating pointer grants next ready port
`timescale 1ns/1ps
`default_nettype none

module vfe_forward_ctl #(
    parameter int PORTS = 4
)(
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic [11:0]       paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              linkClk,
    input  wire logic [PORTS-1:0]  rxLineRdy,
    input  wire logic [PORTS-1:0]  rxFrameEnd,
    input  wire logic [PORTS-1:0]  rxSyncPkt,
    output logic      [PORTS-1:0]  out0Grant,
    output logic      [PORTS-1:0]  out1Grant,
    output logic                   out1Replica,
    output logic                   irq
);
    // ========================================================
    // input synchronisers
    // ========================================================
    localparam int SW = 3*PORTS+1;
    logic [SW-1:0]    meta_q;     // first stage, read by sync only
    logic [SW-1:0]    sync_q;     // second stage, safe to use
    logic             linkPrev_q; // previous link clock level
    logic [PORTS-1:0] rdyS;       // line ready, synchronised
    logic [PORTS-1:0] feS;        // last line of frame
    logic [PORTS-1:0] shortS;     // pending item is a sync packet
    logic             tick;       // rising link clock edge

    // two flops on every receive-side pin before any logic looks
    always_ff @(posedge clk)
    begin
        meta_q <= {linkClk, rxSyncPkt, rxFrameEnd, rxLineRdy};
        sync_q <= meta_q;
    end

    // link edge finder; paces at most one grant per link cycle
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            linkPrev_q <= 1'b0;
        else
            linkPrev_q <= sync_q[SW-1];
    end

    assign rdyS   = sync_q[PORTS-1:0];
    assign feS    = sync_q[2*PORTS-1:PORTS];
    assign shortS = sync_q[3*PORTS-1:2*PORTS];
    assign tick   = sync_q[SW-1] & ~linkPrev_q;

    // ========================================================
    // registers
    // ========================================================
    logic [7:0]  portCtl_q;  // forward-off and output select
    logic [7:0]  modeCtl_q;  // duplicate, when-ready, modes
    logic [1:0]  lost_q;     // sticky alignment lost flags
    logic [1:0]  intSts_q;   // sticky event status
    logic [1:0]  intMask_q;  // event mask
    logic [1:0]  aligned;    // live aligned indications
    logic [1:0]  lostEv;     // loss events from the engines
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;

    // ========================================================
    // apb decode
    // ========================================================
    localparam int ADDR_LSB   = vfe_pkg::ADDR_LSB;
    localparam int ADDR_LSB_W = 8;
    wire [7:0] idx      = paddr[ADDR_LSB_W+ADDR_LSB-1:ADDR_LSB];
    wire       access   = psel & penable & ~pready_q;
    wire       selPort  = idx == vfe_pkg::IDX_PORT_CTL;
    wire       selMode  = idx == vfe_pkg::IDX_MODE_CTL;
    wire       selState = idx == vfe_pkg::IDX_STATE;
    wire       selSts   = idx == vfe_pkg::IDX_INT_STS;
    wire       selMask  = idx == vfe_pkg::IDX_INT_MASK;
    wire       hit      = selPort | selMode | selState
                        | selSts | selMask;
    wire       wrEn     = access & pwrite & hit;
    wire       rdState  = access & ~pwrite & selState;
    wire [7:0] stateVal = {4'h0, lost_q, aligned};
    wire [7:0] rdMux    = selPort  ? portCtl_q :
                          selMode  ? modeCtl_q :
                          selState ? stateVal :
                          selSts   ? {6'h00, intSts_q} :
                          selMask  ? {6'h00, intMask_q} : 8'h00;

    // one wait state: answer comes in the second access cycle
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end
        else
        begin
            pready_q  <= access;
            pslverr_q <= access & ~hit;
            prdata_q  <= (access & ~pwrite) ? {24'h000000, rdMux}
                                            : 32'h0000_0000;
        end
    end

    // writable control registers
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            // [R15] [R16] ports start off, steered to output 0
            portCtl_q <= vfe_pkg::RST_PORT_CTL;
            // [R5] [R6] aligned modes off, rotating on
            modeCtl_q <= vfe_pkg::RST_MODE_CTL;
            intMask_q <= 2'b00;
        end
        else if (wrEn)
        begin
            if (selPort)
                portCtl_q <= pwdata[7:0];
            if (selMode)
                modeCtl_q <= pwdata[7:0];
            if (selMask)
                intMask_q <= pwdata[1:0];
        end
    end

    // sticky flags: a new event wins over the clear
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            lost_q   <= 2'b00;
            intSts_q <= 2'b00;
        end
        else
        begin
            // [R12] read returns the flag, then clears it
            lost_q   <= (rdState ? 2'b00 : lost_q) | lostEv;
            intSts_q <= (wrEn & selSts ? intSts_q & ~pwdata[1:0]
                                       : intSts_q) | lostEv;
        end
    end

    // ========================================================
    // forwarding engines, one per output
    // ========================================================
    wire [PORTS-1:0] fwdOff  = portCtl_q[vfe_pkg::POS_OFF +: PORTS];
    wire [PORTS-1:0] portSel = portCtl_q[vfe_pkg::POS_SEL +: PORTS];
    wire             whenRdy = modeCtl_q[vfe_pkg::POS_WHENRDY];
    wire             replica = modeCtl_q[vfe_pkg::POS_REPL];
    // local name for the aligned mode encoding, needed by the engines
    typedef vfe_pkg::vfe_align_t vfe_align_sel_t;
    logic [PORTS-1:0] gnt [2]; // combinational grant per engine

    // next ready port after the pointer, wrapping round
    function automatic logic [PORTS-1:0] nextPort(
        input logic [PORTS-1:0]         req,
        input logic [$clog2(PORTS)-1:0] ptr
    );
        logic [PORTS-1:0] res;
        int               k;
        res = '0;
        for (int i = PORTS; i >= 1; i--)
        begin
            k = (int'(ptr) + i) % PORTS;
            if (req[k])
                res = '0 | (PORTS'(1) << k);
        end
        return res;
    endfunction : nextPort

    // index of a one-hot grant, for the pointer
    function automatic logic [$clog2(PORTS)-1:0] oneHotIdx(
        input logic [PORTS-1:0] oh
    );
        logic [$clog2(PORTS)-1:0] r;
        r = '0;
        for (int i = 0; i < PORTS; i++)
            if (oh[i])
                r = ($clog2(PORTS))'(i);
        return r;
    endfunction : oneHotIdx

    for (genvar o = 0; o < 2; o++)
    begin : g_eng
        logic [$clog2(PORTS)-1:0] ptr_q;  // last port served
        logic                     sent_q; // one aligned frame out
        logic                     aln_q;  // aligned now
        logic [PORTS-1:0]         memb;   // enabled ports mapped here
        logic [PORTS-1:0]         rdyM;
        logic [PORTS-1:0]         feM;
        logic [PORTS-1:0]         loose;  // lines allowed alone
        logic [PORTS-1:0]         pick;
        vfe_align_sel_t           mode;
        logic                     rrOn;
        logic                     alnOn;
        logic                     allRdy;
        logic                     group;
        logic                     frameOk;
        logic                     broken;

        // [R15] [R16] membership: enabled and steered here
        assign memb = ~fwdOff & (o == 1 ? portSel : ~portSel);
        assign rdyM = rdyS & memb;
        assign feM  = feS & memb;
        // [R5] [R6] per-output mode field
        assign mode = vfe_align_sel_t'(o == 1 ?
                      modeCtl_q[vfe_pkg::POS_OUT1_ALN +: 2] :
                      modeCtl_q[vfe_pkg::POS_OUT0_ALN +: 2]);
        assign rrOn   = modeCtl_q[o];
        assign alnOn  = mode != vfe_pkg::ALN_OFF;
        assign allRdy = (memb != '0) & (rdyM == memb);
        // [R4] no lone sends in concat mode or for sync packets
        assign loose  = (whenRdy & mode != vfe_pkg::ALN_CONCAT)
                      ? rdyM & ~shortS : '0;
        // [R17] rotating choice among candidates
        assign pick   = nextPort(alnOn ? loose : rdyM, ptr_q);
        // [R2] whole group only when every member is ready
        assign group  = tick & alnOn & allRdy;
        assign frameOk = group & (feM == memb);
        assign broken  = group & (feM != '0) & (feM != memb);

        // grant selection; aligned takes precedence if both set
        always_comb
        begin
            if (!tick)
                gnt[o] = '0;
            else if (alnOn & allRdy)
                gnt[o] = memb;
            // [R3] send-when-ready: each line as it comes
            else if (alnOn)
                gnt[o] = pick;
            // [R8] [R9] rotating: no alignment, ready in turn
            else if (rrOn)
                gnt[o] = pick;
            else
                gnt[o] = '0;
        end

        // pointer and alignment tracking
        always_ff @(posedge clk)
        begin
            if (sys_rst)
            begin
                ptr_q  <= '0;
                sent_q <= 1'b0;
                aln_q  <= 1'b0;
            end
            else
            begin
                // [R17] remember the port just served
                if (gnt[o] != '0 && !group)
                    ptr_q <= oneHotIdx(gnt[o]);
                // [R14] sent and aligned flags drop when aligned mode is off
                if (!alnOn)
                begin
                    sent_q <= 1'b0;
                    aln_q  <= 1'b0;
                end
                else if (frameOk)
                begin
                    // [R13] aligned frame fully delivered
                    sent_q <= 1'b1;
                    aln_q  <= 1'b1;
                end
                else if (broken)
                    aln_q  <= 1'b0;
            end
        end

        assign aligned[o] = aln_q;
        // [R10] [R11] loss counts only after a good frame
        assign lostEv[o]  = broken & sent_q;
    end

    // ========================================================
    // registered outputs and interrupt
    // ========================================================
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            out0Grant   <= '0;
            out1Grant   <= '0;
            out1Replica <= 1'b0;
            irq         <= 1'b0;
        end
        else
        begin
            out0Grant   <= gnt[0];
            // [R1] duplicate: output 1 carries output 0's stream
            out1Grant   <= replica ? gnt[0] : gnt[1];
            out1Replica <= replica;
            irq         <= |(intSts_q & intMask_q);
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;
endmodule : vfe_forward_ctl

`default_nettype wire

// file: src/vfe_pkg.sv
// constants shared by the forwarding engine control block
// assumes a 32-bit apb master and a 100 MHz system clock
package vfe_pkg;
    // ========================================================
    // register indexes; byte address is four times the index
    // ========================================================
    localparam logic [7:0] IDX_PORT_CTL  = 8'h20; // port control
    localparam logic [7:0] IDX_MODE_CTL  = 8'h21; // mode control
    localparam logic [7:0] IDX_STATE     = 8'h22; // state flags
    localparam logic [7:0] IDX_INT_STS   = 8'h30; // event status
    localparam logic [7:0] IDX_INT_MASK  = 8'h31; // event mask
    localparam int         ADDR_LSB      = 2;     // word aligned

    // ========================================================
    // reset values
    // ========================================================
    localparam logic [7:0] RST_PORT_CTL  = 8'hf0; // all ports off
    localparam logic [7:0] RST_MODE_CTL  = 8'h03; // rotating on

    // ========================================================
    // field positions
    // ========================================================
    localparam int POS_OFF      = 4; // port forward off [7:4]
    localparam int POS_SEL      = 0; // port output select [3:0]
    localparam int POS_REPL     = 7; // duplicate output 0
    localparam int POS_WHENRDY  = 6; // send when ready
    localparam int POS_OUT1_ALN = 4; // out1 aligned mode [5:4]
    localparam int POS_OUT0_ALN = 2; // out0 aligned mode [3:2]
    localparam int POS_FAIL     = 2; // alignment lost [3:2]
    localparam int POS_ALIGNED  = 0; // aligned now [1:0]

    // ========================================================
    // aligned forwarding modes
    // ========================================================
    typedef enum logic [1:0]
    {
        ALN_OFF    = 2'b00,
        ALN_BASIC  = 2'b01,
        ALN_INTERL = 2'b10,
        ALN_CONCAT = 2'b11
    } vfe_align_t;
endpackage : vfe_pkg

// file: tb/vfe_forward_ctl_sva.sv
// port checker for the forwarding control block
// assumes one apb wait state and registered grant pulses
`timescale 1ns/1ps
`default_nettype none
module vfe_forward_ctl_chk #(
    parameter int PORTS = 4
)(
    input wire logic             clk,
    input wire logic             sys_rst,
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pready,
    input wire logic [PORTS-1:0] rxLineRdy,
    input wire logic [PORTS-1:0] out0Grant,
    input wire logic [PORTS-1:0] out1Grant,
    input wire logic             out1Replica,
    input wire logic             irq
);
    // ====================================================
    // port relations, all in the system clock domain
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_ready_one_wait: assert property ($rose(penable) && psel |=> pready)
        else $error("apb answer not after one wait state");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("apb ready held longer than one cycle");
    a_replica_same: assert property (
        out1Replica |-> out1Grant == out0Grant)
        else $error("replica output differs from output 0");
    a_grant_gap0: assert property (
        |out0Grant |=> (out0Grant == '0) [*8])
        else $error("output 0 grants closer than a link period");
    a_grant_gap1: assert property (
        |out1Grant |=> (out1Grant == '0) [*8])
        else $error("output 1 grants closer than a link period");
    // the source holds its line until granted, so two cycles back it
    // must already have been pending
    a_ready_only: assert property (
        ((out0Grant | out1Grant) & ~$past(rxLineRdy, 2)) == '0)
        else $error("grant issued to a port without a pending line");
    a_outputs_apart: assert property (
        !out1Replica |-> (out0Grant & out1Grant) == '0)
        else $error("one port granted on both outputs");
    a_reset_quiet: assert property ($fell(sys_rst) |->
        !irq && !pready && out0Grant == '0 && out1Grant == '0)
        else $error("outputs not quiet right after reset");
endmodule : vfe_forward_ctl_chk
bind vfe_forward_ctl vfe_forward_ctl_chk #(.PORTS(PORTS)) chk_i (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pready(pready), .rxLineRdy(rxLineRdy), .out0Grant(out0Grant),
    .out1Grant(out1Grant), .out1Replica(out1Replica), .irq(irq));
`default_nettype wire

// file: tb/vfe_rx_source.sv
// receive-side source model: link clock and pending-line levels
// assumes the bench pulses load for one cycle per new line
`timescale 1ns/1ps
`default_nettype none
module vfe_rx_source (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic [3:0] load,
    input  wire logic [3:0] out0Grant,
    input  wire logic [3:0] out1Grant,
    output var  logic       linkClk,
    output var  logic [3:0] rxLineRdy
);
    // ====================================================
    // link clock, unrelated in phase to the system clock
    initial
    begin
        linkClk = 1'h0;
        #3.3;
        forever #62.5 linkClk = ~linkClk;
    end
    // a line stays pending until granted, then drops well before
    // the next link edge so it is never sent twice
    always @(posedge clk)
        rxLineRdy <= sys_rst ? 4'h0
                   : (rxLineRdy & ~(out0Grant | out1Grant)) | load;
endmodule : vfe_rx_source
`default_nettype wire

// file: tb/tb_vfe_forward_ctl.sv
// self-checking bench for the forwarding control block
// assumes the source model answers grants within one cycle
`timescale 1ns/1ps
`default_nettype none
module tb_vfe_forward_ctl;
    typedef struct {
        logic        w; // write when set
        logic [11:0] a; // byte address
        logic [31:0] d; // write data or expected read
        logic        e; // expected error
    } vfe_row_t;
    logic        clk     = 1'h0;
    logic        sys_rst = 1'h1;
    logic [11:0] paddr   = 12'h000;
    logic        psel    = 1'h0;
    logic        penable = 1'h0;
    logic        pwrite  = 1'h0;
    logic [31:0] pwdata  = 32'h0;
    logic [3:0]  load    = 4'h0;
    logic [3:0]  fe      = 4'h0; // frame end levels
    logic [3:0]  sp      = 4'h0; // sync packet levels
    logic [31:0] prdata, rd;
    logic        pready, pslverr, linkClk, out1Replica, irq, er;
    logic [3:0]  rdy, out0Grant, out1Grant;
    int          errors  = 0;
    int          compares = 0;
    // ====================================================
    // register table rows: reset values, modes, unmapped
    vfe_row_t rows [11] = '{
        '{1'h0, 12'h080, 32'hf0, 1'h0}, '{1'h0, 12'h084, 32'h03, 1'h0},
        '{1'h0, 12'h088, 32'h00, 1'h0}, '{1'h0, 12'h0c0, 32'h00, 1'h0},
        '{1'h0, 12'h0c4, 32'h00, 1'h0}, '{1'h1, 12'h084, 32'h34, 1'h0},
        '{1'h0, 12'h084, 32'h34, 1'h0}, '{1'h1, 12'h084, 32'h28, 1'h0},
        '{1'h0, 12'h084, 32'h28, 1'h0}, '{1'h1, 12'h100, 32'h55, 1'h1},
        '{1'h0, 12'h100, 32'h00, 1'h1}};
    vfe_forward_ctl #(.PORTS(4)) vfe_forward_ctl_i (
        .clk(clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .linkClk(linkClk), .rxLineRdy(rdy), .rxFrameEnd(fe),
        .rxSyncPkt(sp), .out0Grant(out0Grant), .out1Grant(out1Grant),
        .out1Replica(out1Replica), .irq(irq));
    vfe_rx_source vfe_rx_source_i (
        .clk(clk), .sys_rst(sys_rst), .load(load),
        .out0Grant(out0Grant), .out1Grant(out1Grant),
        .linkClk(linkClk), .rxLineRdy(rdy));
    initial
    begin
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        compares++;
        if (g !== x)
        begin
            errors++;
            $display("MISMATCH %0t got %h expected %h", $time, g, x);
        end
    endtask : chk
    // one apb transfer; holds the request until ready is sampled
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
        @(posedge clk);
        penable <= 1'h1;
        do
        begin
            @(posedge clk);
            n++;
        end while (pready !== 1'h1 && n < 50);
        chk({31'h0, pready}, 32'h1);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'h0;
    endtask : apb
    task automatic rc(input logic [11:0] a, input logic [31:0] x);
        apb(1'h0, a, 32'h0);
        chk(rd, x);
    endtask : rc
    // one new line per marked port
    task automatic ld(input logic [3:0] m);
        @(posedge clk);
        load <= m;
        @(posedge clk);
        load <= 4'h0;
    endtask : ld
    // waits a bounded span for a grant pulse, zero means none due
    task automatic grab(input logic [3:0] e0, input logic [3:0] e1);
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end while (out0Grant === 4'h0 && out1Grant === 4'h0 && n < 60);
        chk({out0Grant, out1Grant}, {e0, e1});
    endtask : grab
    task automatic irqIs(input logic x);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, {31'h0, x});
    endtask : irqIs
    task automatic test_done;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : test_done
    initial
    begin
        #200us;
        errors++;
        test_done();
    end
    initial
    begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'h0;
        repeat (3) @(posedge clk);
        foreach (rows[i])
        begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) chk(rd, rows[i].d);
            chk({31'h0, er}, {31'h0, rows[i].e});
        end
        $display("done: register rows");
        apb(1'h1, 12'h084, 32'h03);
        apb(1'h1, 12'h080, 32'h00);
        ld(4'h4);
        grab(4'h4, 4'h0);
        ld(4'hb);
        grab(4'h8, 4'h0);
        grab(4'h1, 4'h0);
        grab(4'h2, 4'h0);
        apb(1'h1, 12'h080, 32'h80);
        ld(4'ha);
        grab(4'h2, 4'h0);
        grab(4'h0, 4'h0);
        apb(1'h1, 12'h080, 32'h00);
        grab(4'h8, 4'h0);
        apb(1'h1, 12'h080, 32'h02);
        ld(4'h2);
        grab(4'h0, 4'h2);
        apb(1'h1, 12'h084, 32'h83);
        ld(4'h1);
        grab(4'h1, 4'h1);
        chk({31'h0, out1Replica}, 32'h1);
        $display("done: rotating, mapping, replica");
        apb(1'h1, 12'h080, 32'hc0);
        apb(1'h1, 12'h0c4, 32'h01);
        apb(1'h1, 12'h084, 32'h04);
        fe <= 4'h1;
        ld(4'h1);
        grab(4'h0, 4'h0);
        ld(4'h2);
        grab(4'h3, 4'h0);
        rc(12'h088, 32'h0);
        fe <= 4'h3;
        ld(4'h3);
        grab(4'h3, 4'h0);
        rc(12'h088, 32'h1);
        fe <= 4'h1;
        ld(4'h3);
        grab(4'h3, 4'h0);
        rc(12'h088, 32'h4);
        rc(12'h088, 32'h0);
        rc(12'h0c0, 32'h1);
        irqIs(1'h1);
        apb(1'h1, 12'h0c4, 32'h00);
        irqIs(1'h0);
        apb(1'h1, 12'h0c4, 32'h01);
        irqIs(1'h1);
        apb(1'h1, 12'h0c0, 32'h01);
        irqIs(1'h0);
        // aligned again first, so that switching off must clear it
        fe <= 4'h3;
        ld(4'h3);
        grab(4'h3, 4'h0);
        rc(12'h088, 32'h1);
        apb(1'h1, 12'h084, 32'h03);
        rc(12'h088, 32'h0);
        $display("done: aligned, loss, interrupt");
        fe <= 4'h0;
        apb(1'h1, 12'h084, 32'h44);
        ld(4'h1);
        grab(4'h1, 4'h0);
        // a pending sync packet never goes out alone
        sp <= 4'h1;
        ld(4'h1);
        grab(4'h0, 4'h0);
        ld(4'h2);
        grab(4'h3, 4'h0);
        sp <= 4'h0;
        apb(1'h1, 12'h084, 32'h4c);
        ld(4'h1);
        grab(4'h0, 4'h0);
        ld(4'h2);
        grab(4'h3, 4'h0);
        $display("done: send when ready");
        // reset in mid-run brings back the default configuration
        @(posedge clk);
        sys_rst <= 1'h1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'h0;
        rc(12'h084, 32'h03);
        rc(12'h080, 32'hf0);
        $display("done: mid-run reset");
        test_done();
    end
endmodule : tb_vfe_forward_ctl
`default_nettype wire
